// File: memory_ordering_lock_string_tb.sv
`timescale 1ns/1ps

module memory_ordering_lock_string_tb;
  typedef struct {logic [1:0] kind; logic ld; logic fast; logic [31:0] addr;
                  logic [15:0] cnt; int expAcc;} mols_row_t;
  logic clk, srst, fastStringEn, opValid, opIsLoad, opReady, intrReq, slow;
  logic memValid, memWrite, memLocked, memAccept, memVisible, stringBusy, interrupted;
  logic [1:0] opKind;
  logic [31:0] opAddr, opData, memAddr, memData, nextA, stepA;
  logic [15:0] opCount, remainCount, rem;
  logic prevV, first, seenLock, ordAll;
  int fail_count = 0;
  int num_checks = 0;
  int wr = 0;
  int vis = 0;
  int acc = 0;
  mols_row_t rows[11];

  mols_order_ctrl uut (.clk(clk), .srst(srst), .fastStringEn(fastStringEn), .opValid(opValid),
    .opKind(opKind), .opAddr(opAddr), .opData(opData), .opCount(opCount), .opIsLoad(opIsLoad),
    .opReady(opReady), .intrReq(intrReq), .memValid(memValid), .memWrite(memWrite),
    .memLocked(memLocked), .memAddr(memAddr), .memData(memData), .memAccept(memAccept),
    .memVisible(memVisible), .stringBusy(stringBusy), .remainCount(remainCount),
    .interrupted(interrupted));
  mols_mem_model mem (.clk(clk), .srst(srst), .slow(slow), .memValid(memValid),
    .memWrite(memWrite), .memAccept(memAccept), .memVisible(memVisible));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // monitor: drain before each ordered request
  // ----------------------------------------
  always @(posedge clk) begin
    if (memVisible) vis++;
    if (memValid && !prevV && (ordAll || first)) check("drain", wr, vis);
    if (memValid && !prevV) first = 1'b0;
    if (memValid && memAccept) begin
      acc++;
      if (memWrite) wr++;
      if (memLocked) seenLock = 1'b1;
      // fast strings may reorder elements, so addresses are only checked when ordered
      if (ordAll) check("addr", memAddr, nextA);
      if (memWrite) check("data", memData, opData);
      check("kind", {memWrite, memLocked}, {!opIsLoad, opKind == mols_pkg::ST_SEQ_LOCK});
      nextA = nextA + stepA;
    end
    prevV = memValid;
  end

  task automatic run(mols_row_t r);
    int n;
    int idle;
    @(posedge clk);
    #1;
    {opValid, opKind, opIsLoad, fastStringEn, opAddr, opCount} = {1'b1, r.kind, r.ld, r.fast, r.addr, r.cnt};
    opData = r.addr ^ 32'h5a5a_0000;
    {acc, first, seenLock, nextA} = {32'h0, 1'b1, 1'b0, r.addr};
    stepA = (r.kind == mols_pkg::ST_SEQ_STRING) ? mols_pkg::ELEM_STEP : 32'h0;
    ordAll = !(r.kind == mols_pkg::ST_SEQ_STRING && r.fast);
    for (n = 0; n < 50 && opReady !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check("taken", opReady, 1'b1);
    opValid = 1'b0;
    idle = 0;
    for (n = 0; n < 600 && idle < 6; n++) begin
      @(posedge clk);
      #1;
      idle = (memValid === 1'b0 && wr == vis && stringBusy === 1'b0) ? idle + 1 : 0;
    end
    check("timeout", idle >= 6, 1'b1);
  endtask : run

  initial begin
    {srst, fastStringEn, opValid, opKind, opIsLoad, intrReq, slow, prevV} = {1'b1, 8'h0};
    {opAddr, opData, opCount, first, seenLock, ordAll, nextA, stepA} = '0;
    rows = '{'{2'h0, 1'b0, 1'b0, 32'h100, 16'h1, 1}, '{2'h0, 1'b1, 1'b0, 32'h104, 16'h1, 1},
             '{2'h1, 1'b0, 1'b0, 32'h200, 16'h5, 5}, '{2'h1, 1'b0, 1'b1, 32'h300, 16'h6, 6},
             '{2'h0, 1'b0, 1'b0, 32'h400, 16'h1, 1}, '{2'h2, 1'b0, 1'b0, 32'h500, 16'h1, 1},
             '{2'h2, 1'b1, 1'b0, 32'h504, 16'h1, 1}, '{2'h1, 1'b0, 1'b0, 32'h600, 16'h0, 0},
             '{2'h1, 1'b0, 1'b1, 32'h700, 16'h4, 4}, '{2'h0, 1'b1, 1'b0, 32'h108, 16'h1, 1},
             '{2'h1, 1'b0, 1'b1, 32'h1000, 16'h40, 64}};
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    check("reset", {memValid, opReady, stringBusy, interrupted}, 4'h0);
    foreach (rows[i]) begin
      slow = i[0];
      run(rows[i]);
      if (rows[i].expAcc >= 0) check("accesses", acc, rows[i].expAcc);
      if (rows[i].kind == mols_pkg::ST_SEQ_LOCK) check("locked", seenLock, 1'b1);
    end
    // ----------------------------------------
    // interrupted string, handler store, resume
    // ----------------------------------------
    intrReq = 1'b1;
    run('{2'h1, 1'b0, 1'b0, 32'h800, 16'h8, -1});
    intrReq = 1'b0;
    rem = remainCount;
    check("intr", interrupted, 1'b1);
    check("split", acc + rem, 8);
    run('{2'h0, 1'b0, 1'b0, 32'h900, 16'h1, 1});
    run('{2'h1, 1'b0, 1'b0, 32'h820 - {rem, 2'h0}, rem, -1});
    check("resume", acc, rem);
    // ----------------------------------------
    // reset in the middle of a string op, then a plain store
    // ----------------------------------------
    @(posedge clk);
    #1;
    {opValid, opKind, fastStringEn, opCount, ordAll} = {1'b1, mols_pkg::ST_SEQ_STRING, 1'b1, 16'h8, 1'b0};
    repeat (6) @(posedge clk);
    #1;
    check("busy", stringBusy, 1'b1);
    {srst, opValid} = 2'b10;
    repeat (2) @(posedge clk);
    #1;
    // counts cleared only once the reset edges have passed the monitor
    {wr, vis} = '0;
    check("reset", {memValid, opReady, stringBusy, interrupted, remainCount}, 32'h0);
    srst = 1'b0;
    run('{2'h0, 1'b0, 1'b0, 32'ha00, 16'h1, 1});
    check("accesses", acc, 1);
    complete_run();
  end
endmodule : memory_ordering_lock_string_tb

// File: mols_drain_count.sv
`timescale 1ns/1ps

// counts stores that entered the buffer but are not yet globally visible
module mols_drain_count #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         incr,
  input  wire logic         decr,
  output logic              empty,
  output logic [W-1:0]      count
);

  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= '0;
    end else begin
      case ({incr, decr})
        2'b10:   cnt_ff <= cnt_ff + W'(1);
        2'b01:   cnt_ff <= cnt_ff - W'(1);
        default: cnt_ff <= cnt_ff;
      endcase
    end
  end

  assign count = cnt_ff;
  assign empty = (cnt_ff == '0);

endmodule : mols_drain_count

// File: mols_mem_model.sv
`timescale 1ns/1ps

// far side: accepts after a short or long wait, reports each write visible later
module mols_mem_model (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic slow,
  input  wire logic memValid,
  input  wire logic memWrite,
  output logic      memAccept,
  output logic      memVisible
);
  int dly;
  int pend;
  int age;

  always_ff @(posedge clk) begin
    memAccept  <= 1'b0;
    memVisible <= 1'b0;
    if (srst) begin
      dly  <= 0;
      pend <= 0;
      age  <= 0;
    end else begin
      dly <= (memValid && !memAccept) ? dly + 1 : 0;
      if (memValid && !memAccept && dly >= (slow ? 3 : 0)) begin
        memAccept <= 1'b1;
      end
      // slow mode keeps several writes in flight at once
      age        <= (pend > 0 && !memVisible) ? age + 1 : 0;
      memVisible <= pend > 0 && !memVisible && age >= (slow ? 5 : 1);
      pend       <= pend + int'(memValid && memAccept && memWrite) - int'(memVisible);
    end
  end
endmodule : mols_mem_model

// File: mols_order_ctrl.sv
`timescale 1ns/1ps

// Functional notes
// - a load never performs while any locked instruction older or younger is unfinished.
// - a store after a locked exchange stays invisible until the exchange's write is visible.
// - with fast strings on, element stores of one string op may be made visible in any order.
// - no store of a later string op is visible before all stores of an earlier one are.
// - an ordinary store after a string op is held until all the string op's stores are visible.
// - an interrupted string op keeps only its done part ordered; handler stores may pass it.
// - no string op store is visible before every store older than the string op.
// - a doubleword string store writes one 4-byte element per iteration at rising addresses.
// - locked instructions are issued to memory one at a time, giving one global order.
// - loads perform in program order, one at a time, each after the previous returned.
module mols_order_ctrl #(
  parameter int unsigned ADDR_W = mols_pkg::ADDR_W,
  parameter int unsigned DATA_W = mols_pkg::DATA_W,
  parameter int unsigned CNT_W  = mols_pkg::CNT_W
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              fastStringEn,
  // instruction stream (program order)
  input  wire logic              opValid,
  input  wire logic [1:0]        opKind,
  input  wire logic [ADDR_W-1:0] opAddr,
  input  wire logic [DATA_W-1:0] opData,
  input  wire logic [CNT_W-1:0]  opCount,
  input  wire logic              opIsLoad,
  output logic                   opReady,
  input  wire logic              intrReq,
  // memory side
  output logic                   memValid,
  output logic                   memWrite,
  output logic                   memLocked,
  output logic [ADDR_W-1:0]      memAddr,
  output logic [DATA_W-1:0]      memData,
  input  wire logic              memAccept,
  input  wire logic              memVisible,
  output logic                   stringBusy,
  output logic [CNT_W-1:0]       remainCount,
  output logic                   interrupted
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_DRAIN = 5'h02,
    S_ISSUE = 5'h04,
    S_WAIT  = 5'h08,
    S_STR   = 5'h10
  } mols_state_t;

  typedef struct packed {
    mols_state_t       st;
    logic              write;
    logic              locked;
    logic              isString;
    logic              memValid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [CNT_W-1:0]  remain;
    logic              ready;
    logic              intr;
    logic              busy;
  } mols_regs_t;

  // the pending counter is narrow; fast strings stop on the accept that fills it so it never wraps to empty
  localparam int unsigned       PEND_W    = 4;
  localparam logic [PEND_W-1:0] PEND_FULL = '1;

  mols_regs_t        r_ff;
  mols_regs_t        nxt_r;
  logic              pendEmpty;
  logic              issueFire;
  logic [PEND_W-1:0] pendCount;

  function automatic logic [ADDR_W-1:0] nextElem(input logic [ADDR_W-1:0] a);
    nextElem = a + mols_pkg::ELEM_STEP;
  endfunction : nextElem

  assign issueFire = r_ff.memValid && memAccept;

  mols_drain_count #(
    .W (PEND_W)
  ) u_pend (
    .clk   (clk),
    .srst  (srst),
    .incr  (issueFire && r_ff.write),
    .decr  (memVisible),
    .empty (pendEmpty),
    .count (pendCount)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_r.ready = 1'b0;
    case (r_ff.st)
      S_IDLE: begin
        if (opValid && !r_ff.ready) begin
          nxt_r.ready    = 1'b1;
          nxt_r.addr     = opAddr;
          nxt_r.data     = opData;
          nxt_r.write    = !opIsLoad;
          nxt_r.locked   = (opKind == mols_pkg::ST_SEQ_LOCK);
          nxt_r.isString = (opKind == mols_pkg::ST_SEQ_STRING);
          nxt_r.remain   = opCount;
          nxt_r.intr     = 1'b0;
          // every op waits for older stores before its first access: string ops after string
          // locked ops loads around locks
          nxt_r.st       = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (pendEmpty) begin
          if (r_ff.isString && r_ff.remain == '0) begin
            nxt_r.st = S_IDLE;
          end else begin
            nxt_r.memValid = 1'b1;
            nxt_r.st       = r_ff.isString ? S_STR : S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        if (memAccept) begin
          nxt_r.memValid = 1'b0;
          nxt_r.st       = S_WAIT;
        end
      end
      S_WAIT: begin
        // locked write must be visible; loads return one at a time
        if (pendEmpty) begin
          nxt_r.st = S_IDLE;
        end
      end
      S_STR: begin
        if (memAccept) begin
          nxt_r.addr   = nextElem(r_ff.addr);
          nxt_r.remain = r_ff.remain - CNT_W'(1);
          // fast strings stream elements without per-element visibility
          if (r_ff.remain == CNT_W'(1)) begin
            nxt_r.memValid = 1'b0;
            nxt_r.st       = S_WAIT;
          end else if (intrReq) begin
            // done part drains, rest resumes later
            nxt_r.memValid = 1'b0;
            nxt_r.intr     = 1'b1;
            nxt_r.st       = S_WAIT;
          // headroom: this accept could fill the counter, so drain before the next
          end else if (!fastStringEn || pendCount >= PEND_FULL - PEND_W'(1)) begin
            nxt_r.memValid = 1'b0;
            nxt_r.st       = S_DRAIN;
          end
        end
      end
      default: begin
        nxt_r.st = S_IDLE;
      end
    endcase
    // registered so the status pin comes straight from a flop
    nxt_r.busy = nxt_r.isString && (nxt_r.st != S_IDLE);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r_ff <= '{st: S_IDLE, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign opReady     = r_ff.ready;
  assign memValid    = r_ff.memValid;
  assign memWrite    = r_ff.write;
  assign memLocked   = r_ff.locked;
  assign memAddr     = r_ff.addr;
  assign memData     = r_ff.data;
  assign stringBusy  = r_ff.busy;
  assign remainCount = r_ff.remain;
  assign interrupted = r_ff.intr;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence seqIssue;
    memValid && memAccept;
  endsequence

  a_lock_drained: assert property (@(posedge clk) disable iff (srst)
    (r_ff.st == S_DRAIN && !pendEmpty) |=> !memValid)
    else $error("access issued over older stores");
  a_lock_visible: assert property (@(posedge clk) disable iff (srst)
    (seqIssue and memLocked) |=> (r_ff.st == S_WAIT) [*1] ##0 !memValid)
    else $error("access passed a locked write");
  a_str_step: assert property (@(posedge clk) disable iff (srst)
    (seqIssue and r_ff.st == S_STR) |=> memAddr == $past(memAddr) + mols_pkg::ELEM_STEP)
    else $error("string element step wrong");
  a_str_count: assert property (@(posedge clk) disable iff (srst)
    (seqIssue and r_ff.st == S_STR) |=> remainCount == $past(remainCount) - CNT_W'(1))
    else $error("string count wrong");
  a_load_single: assert property (@(posedge clk) disable iff (srst)
    (seqIssue and !memWrite) |=> !memValid [*2])
    else $error("second load issued early");
  a_intr_stop: assert property (@(posedge clk) disable iff (srst)
    (seqIssue and r_ff.st == S_STR && intrReq && remainCount > CNT_W'(1)) |=> interrupted)
    else $error("interrupt not taken");
  a_str_fence: assert property (@(posedge clk) disable iff (srst)
    (r_ff.st == S_WAIT && !pendEmpty) |=> r_ff.st == S_WAIT)
    else $error("left wait before visible");
  a_issue_idle: assert property (@(posedge clk) disable iff (srst)
    (r_ff.st == S_IDLE) |-> !memValid)
    else $error("issue without order check");
  a_pend_room: assert property (@(posedge clk) disable iff (srst)
    (issueFire && r_ff.write) |-> pendCount != PEND_FULL)
    else $error("write issued with pending counter full");
  a_str_ordered: assert property (@(posedge clk) disable iff (srst)
    (seqIssue and r_ff.st == S_STR && !fastStringEn) |=> !memValid)
    else $error("element streamed with fast strings off");

endmodule : mols_order_ctrl

// File: mols_pkg.sv
package mols_pkg;

  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned CNT_W        = 16;
  localparam int unsigned ELEM_BYTES   = 4;
  localparam int unsigned SB_DEPTH     = 8;
  localparam int unsigned CLK_PERIOD_NS = 8;

  localparam logic [1:0] ST_SEQ_STORE  = 2'h0;
  localparam logic [1:0] ST_SEQ_STRING = 2'h1;
  localparam logic [1:0] ST_SEQ_LOCK   = 2'h2;

  localparam logic [ADDR_W-1:0] ELEM_STEP = 32'h0000_0004;

endpackage : mols_pkg
